// File: rtl/cdcseq_decimator.sv
module cdcseq_decimator
  import cdcseq_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        restart,
  input  wire logic                        sample_en,
  input  wire logic [cdcseq_pkg::DATA_W-1:0] sample_data,
  input  wire logic                        ratio_128,
  output logic                             done_q,
  output logic [cdcseq_pkg::DATA_W-1:0]    result_q
);

  logic [SUM_W-1:0]    sum_q;
  logic [SCOUNT_W-1:0] count_q;
  logic [SUM_W-1:0]    total;
  logic [SUM_W-1:0]    scaled;
  logic [SCOUNT_W-1:0] target;

  always_comb begin
    total  = sum_q + {{(SUM_W-DATA_W){1'b0}}, sample_data};
    target = ratio_128 ? SAMPLES_128 : SAMPLES_256;
    // Divide by 3 x ratio: shift out the ratio, then a constant divide
    scaled = ratio_128 ? (total >> 7) : (total >> 8);
  end

  always_ff @(posedge clk) begin
    if (reset || restart) begin
      sum_q   <= '0;
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sample_en) begin
        if (count_q >= target) begin
          sum_q   <= '0;
          count_q <= '0;
          done_q  <= 1'b1;
        end else begin
          sum_q   <= total;
          count_q <= count_q + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= '0;
    end else if (sample_en && count_q >= target) begin
      result_q <= DATA_W'(scaled / 26'h0000003);
    end
  end

endmodule

// File: rtl/cdcseq_pkg.sv
package cdcseq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 16;
  localparam int STAGES     = 8;
  localparam int STAGE_W    = 3;
  localparam int OFFSET_W   = 7;
  localparam int SUM_W      = 26;
  localparam int SCOUNT_W   = 10;
  localparam int MS_W       = 10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int SAMPLE_RATE_HZ  = 250_000;
  localparam int SAMPLE_DIV      = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int MS_CYCLES       = CLK_HZ / 1000;
  localparam int WAKE_STEP_MS    = 200;
  localparam int TOUCH_PERIOD_MS = 25;
  localparam logic [SCOUNT_W-1:0] SAMPLES_256 = 10'h2FF;  // 3 x 256 - 1
  localparam logic [SCOUNT_W-1:0] SAMPLES_128 = 10'h17F;  // 3 x 128 - 1

  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFFS_CTRL       = 10'h000;
  localparam logic [ADDR_W-1:0] OFFS_RAW_RESULT = 10'h00B;
  localparam logic [ADDR_W-1:0] OFFS_SEQ_CFG    = 10'h040;
  localparam logic [ADDR_W-1:0] OFFS_STATUS     = 10'h041;
  localparam logic [ADDR_W-1:0] OFFS_STAGE_CFG  = 10'h080;  // +stage, bank 2
  localparam logic [ADDR_W-1:0] OFFS_STAGE_RES  = 10'h0E0;  // +stage, bank 3

  localparam logic [DATA_W-1:0] CTRL_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0] SEQ_CFG_RESET   = 16'h0007;
  localparam logic [DATA_W-1:0] STAGE_CFG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DECIM_256 = 2'h0;
  localparam logic [1:0] DECIM_128 = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_LOW  = 2'h2;

  typedef struct packed {
    logic [5:0] unused_hi;
    logic [1:0] decimation;
    logic [3:0] unused_mid;
    logic [1:0] wakeup_delay_select;
    logic [1:0] power_mode;
  } cdcseq_ctrl_type;

  typedef struct packed {
    logic [3:0]         diff_pair_en;
    logic [7:0]         cal_enable;
    logic               unused;
    logic [STAGE_W-1:0] last_stage;
  } cdcseq_seq_type;

  typedef struct packed {
    logic                unused_hi;
    logic [OFFSET_W-1:0] negative_offset_setting;
    logic                unused_lo;
    logic [OFFSET_W-1:0] positive_offset_setting;
  } cdcseq_stage_cfg_type;

  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_CONVERT = 2'b01,
    SEQ_WAIT    = 2'b10
  } cdcseq_state_type;

endpackage

// File: rtl/cdcseq_top.sv
// How it works
// - Ctrl bits 9:8 pick ratio 256 or 128.
// - Stage result averages three times ratio samples.
// - Converter samples at 250 kHz, 16-bit results.
// - Sequence time equals stage time times stages.
// - Sequence runs stage 0 to last-stage index.
// - At most eight stages per sequence.
// - Each stage has its own bank 2 settings.
// - Differential pair reports one button, never both.
// - Ctrl bits 3:2 pick 200-800 ms wake delay.
// - Low power wakes, converts once, then waits.
// - Raw 16-bit result readable at 0x00B.
// - Per-stage results readable in bank 3.
// - Per-stage positive and negative 7-bit offsets.
// - Mode bits: 00 full, 10 low, else shutdown.
// - Touched in low power: sequence every 25 ms.
module cdcseq_top
  import cdcseq_pkg::*;
#(
  parameter int MS_TICK_CYCLES = cdcseq_pkg::MS_CYCLES
)
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [cdcseq_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cdcseq_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [cdcseq_pkg::DATA_W-1:0] reg_rdata_q,
  input  wire logic [cdcseq_pkg::DATA_W-1:0] conv_sample,
  output logic                               sample_strobe_q,
  input  wire logic [7:0]                    button_raw,
  output logic      [7:0]                    button_status_q,
  output logic      [cdcseq_pkg::STAGE_W-1:0] active_stage_q,
  output logic      [cdcseq_pkg::OFFSET_W-1:0] positive_offset_setting_q,
  output logic      [cdcseq_pkg::OFFSET_W-1:0] negative_offset_setting_q,
  output logic                               converting_q
);

  cdcseq_ctrl_type      ctrl_q;
  cdcseq_seq_type       seq_q;
  cdcseq_stage_cfg_type stage_cfg_q [STAGES];
  logic [DATA_W-1:0]    stage_res_q [STAGES];
  logic [DATA_W-1:0]    raw_result_q;
  cdcseq_state_type     state_q;
  logic [5:0]           div_q;
  logic [31:0]          ms_div_q;
  logic                 ms_tick;
  logic [MS_W-1:0]      since_start_q;
  logic [MS_W-1:0]      since_end_q;
  logic                 restart_q;
  logic                 dec_done;
  logic [DATA_W-1:0]    dec_result;
  logic                 mode_full;
  logic                 mode_low;
  logic                 touched;
  logic [MS_W-1:0]      wake_delay_ms;
  logic [7:0]           button_pairs;

  // ----------------------------------------------------------------
  // Mode decode and rate dividers
  // ----------------------------------------------------------------
  always_comb begin
    mode_full     = (ctrl_q.power_mode == MODE_FULL);
    mode_low      = (ctrl_q.power_mode == MODE_LOW);
    touched       = |button_raw;
    wake_delay_ms = MS_W'(WAKE_STEP_MS) *
                    ({8'h00, ctrl_q.wakeup_delay_select} + 10'h001);
    ms_tick       = (ms_div_q == 32'(MS_TICK_CYCLES - 1));
  end

  always_ff @(posedge clk) begin
    if (reset || div_q == 6'(SAMPLE_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // One enable per 4 us converter sample, only while converting
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_strobe_q <= 1'b0;
    end else begin
      // Gated by the mode too, so a strobe never outlives converting_q on shutdown
      sample_strobe_q <= (div_q == 6'(SAMPLE_DIV - 1)) && (state_q == SEQ_CONVERT) &&
                         (mode_full || mode_low);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || ms_tick) begin
      ms_div_q <= '0;
    end else begin
      ms_div_q <= ms_div_q + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Decimation filter
  // ----------------------------------------------------------------
  cdcseq_decimator u_decimator (
    .clk         (clk),
    .reset       (reset),
    .restart     (restart_q),
    .sample_en   (sample_strobe_q),
    .sample_data (conv_sample),
    .ratio_128   (ctrl_q.decimation == DECIM_128),
    .done_q      (dec_done),
    .result_q    (dec_result)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Stage time is fixed by the sample count, so a sequence lasts
  // (last_stage + 1) stage times with no gap between stages.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q        <= SEQ_IDLE;
      active_stage_q <= '0;
      restart_q      <= 1'b1;
      converting_q   <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (!mode_full && !mode_low) begin
        state_q        <= SEQ_IDLE;
        active_stage_q <= '0;
        restart_q      <= 1'b1;
        converting_q   <= 1'b0;
      end else begin
        unique case (state_q)
          SEQ_IDLE: begin
            state_q        <= SEQ_CONVERT;
            active_stage_q <= '0;
            restart_q      <= 1'b1;
            converting_q   <= 1'b1;
          end
          SEQ_CONVERT: begin
            if (dec_done) begin
              restart_q <= 1'b1;
              if (active_stage_q == seq_q.last_stage) begin
                active_stage_q <= '0;
                if (mode_low) begin
                  state_q      <= SEQ_WAIT;
                  converting_q <= 1'b0;
                end
              end else begin
                active_stage_q <= active_stage_q + 3'h1;
              end
            end
          end
          SEQ_WAIT: begin
            if (mode_full ||
                (touched && since_start_q >= MS_W'(TOUCH_PERIOD_MS)) ||
                since_end_q >= wake_delay_ms) begin
              state_q      <= SEQ_CONVERT;
              restart_q    <= 1'b1;
              converting_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Low power wait timers in milliseconds; saturate rather than wrap
  always_ff @(posedge clk) begin
    // Cleared at each sequence start, so the touch period runs start to start
    if (reset || (state_q == SEQ_CONVERT && restart_q && active_stage_q == '0)) begin
      since_start_q <= '0;
    end else if (ms_tick && since_start_q != '1) begin
      since_start_q <= since_start_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q != SEQ_WAIT) begin
      since_end_q <= '0;
    end else if (ms_tick && since_end_q != '1) begin
      since_end_q <= since_end_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Results and stage outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      raw_result_q <= '0;
    end else if (dec_done && state_q == SEQ_CONVERT) begin
      raw_result_q <= dec_result;
    end
  end

  always_ff @(posedge clk) begin
    if (dec_done && state_q == SEQ_CONVERT) begin
      stage_res_q[active_stage_q] <= dec_result;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      positive_offset_setting_q <= '0;
      negative_offset_setting_q <= '0;
    end else begin
      positive_offset_setting_q <= stage_cfg_q[active_stage_q].positive_offset_setting;
      negative_offset_setting_q <= stage_cfg_q[active_stage_q].negative_offset_setting;
    end
  end

  // ----------------------------------------------------------------
  // Differential button pairs
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_pair
    always_comb begin
      if (seq_q.diff_pair_en[p]) begin
        button_pairs[2*p]   = button_raw[2*p] & ~button_raw[2*p+1];
        button_pairs[2*p+1] = button_raw[2*p+1] & ~button_raw[2*p];
      end else begin
        button_pairs[2*p]   = button_raw[2*p];
        button_pairs[2*p+1] = button_raw[2*p+1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      button_status_q <= '0;
    end else begin
      button_status_q <= button_pairs;
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= cdcseq_ctrl_type'(CTRL_RESET);
      seq_q  <= cdcseq_seq_type'(SEQ_CFG_RESET);
    end else if (reg_write) begin
      if (reg_addr == OFFS_CTRL) begin
        ctrl_q <= cdcseq_ctrl_type'(reg_wdata);
      end
      if (reg_addr == OFFS_SEQ_CFG) begin
        seq_q <= cdcseq_seq_type'(reg_wdata);
      end
    end
  end

  for (genvar s = 0; s < STAGES; s++) begin : g_stage_cfg
    always_ff @(posedge clk) begin
      if (reset) begin
        stage_cfg_q[s] <= cdcseq_stage_cfg_type'(STAGE_CFG_RESET);
      end else if (reg_write && reg_addr == OFFS_STAGE_CFG + ADDR_W'(s)) begin
        stage_cfg_q[s] <= cdcseq_stage_cfg_type'(reg_wdata);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (reg_read) begin
      if (reg_addr == OFFS_CTRL) begin
        reg_rdata_q <= ctrl_q;
      end else if (reg_addr == OFFS_RAW_RESULT) begin
        reg_rdata_q <= raw_result_q;
      end else if (reg_addr == OFFS_SEQ_CFG) begin
        reg_rdata_q <= seq_q;
      end else if (reg_addr == OFFS_STATUS) begin
        reg_rdata_q <= {button_status_q, 2'h0, converting_q, state_q, active_stage_q};
      end else if (reg_addr[ADDR_W-1:STAGE_W] == OFFS_STAGE_CFG[ADDR_W-1:STAGE_W]) begin
        reg_rdata_q <= stage_cfg_q[reg_addr[STAGE_W-1:0]];
      end else if (reg_addr[ADDR_W-1:STAGE_W] == OFFS_STAGE_RES[ADDR_W-1:STAGE_W]) begin
        reg_rdata_q <= stage_res_q[reg_addr[STAGE_W-1:0]];
      end else begin
        reg_rdata_q <= '0;
      end
    end
  end

endmodule

// File: test/cdcseq_conv_model.sv
module cdcseq_conv_model (
  input  wire logic                           sample_strobe_q,
  input  wire logic [cdcseq_pkg::STAGE_W-1:0] active_stage_q,
  output logic      [cdcseq_pkg::DATA_W-1:0]  conv_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  import cdcseq_pkg::*;
  logic [DATA_W-1:0] level;
  // A distinct level per stage shows which stage a result came from
  assign level = 16'h1000 + 16'h0111 * {13'h0, active_stage_q};
  // Off the strobe the word is stale; its inverse exposes a mistimed sample
  assign conv_sample = sample_strobe_q ? level : ~level;
endmodule

// File: test/cdcseq_top_asserts.sv
module cdcseq_top_asserts #(
  parameter int MS_TICK_CYCLES = cdcseq_pkg::MS_CYCLES
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [9:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata_q,
  input wire logic [15:0] conv_sample,
  input wire logic        sample_strobe_q,
  input wire logic [7:0]  button_raw,
  input wire logic [7:0]  button_status_q,
  input wire logic [2:0]  active_stage_q,
  input wire logic [6:0]  positive_offset_setting_q,
  input wire logic [6:0]  negative_offset_setting_q,
  input wire logic        converting_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import cdcseq_pkg::*;

  // ----------------------------------------------------------------
  // Shadows of host writes and stage history
  // ----------------------------------------------------------------
  cdcseq_ctrl_type     ctrl_q;
  cdcseq_seq_type      seq_q;
  logic [2:0]          stg_p_q;
  logic                conv_p_q;
  logic [SCOUNT_W-1:0] cnt_q;
  logic [SCOUNT_W-1:0] n_exp;
  logic                moved;

  assign moved = (active_stage_q != stg_p_q) || (converting_q && !conv_p_q);
  // Ratio comes from the shadow, so a stage is judged by the ratio in force when it ends
  assign n_exp = (ctrl_q.decimation == DECIM_128) ? SAMPLES_128 + 10'h1 : SAMPLES_256 + 10'h1;

  always_ff @(posedge clk) begin
    if (reset) ctrl_q <= CTRL_RESET;
    else if (reg_write && reg_addr == OFFS_CTRL) ctrl_q <= reg_wdata;
  end

  always_ff @(posedge clk) begin
    if (reset) seq_q <= SEQ_CFG_RESET;
    else if (reg_write && reg_addr == OFFS_SEQ_CFG) seq_q <= reg_wdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stg_p_q  <= 3'h0;
      conv_p_q <= 1'b0;
      cnt_q    <= '0;
    end else begin
      stg_p_q  <= active_stage_q;
      conv_p_q <= converting_q;
      cnt_q    <= (moved ? '0 : cnt_q) + SCOUNT_W'(sample_strobe_q);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence shut_req;
    reg_write && reg_addr == OFFS_CTRL && reg_wdata[0];
  endsequence
  sequence stopped;
    !converting_q && active_stage_q == 3'h0;
  endsequence
  sequence quiet_8;
    !sample_strobe_q [*8];
  endsequence

  a_stage_sample_count: assert property (
    moved && conv_p_q && converting_q |-> cnt_q == n_exp
  ) else $error("stage ended after wrong sample count");
  a_stage_in_range: assert property (
    converting_q |-> active_stage_q <= seq_q.last_stage
  ) else $error("stage beyond last stage");
  a_stage_order: assert property (
    moved && conv_p_q && converting_q |-> active_stage_q == stg_p_q + 3'h1
      || (active_stage_q == 3'h0 && stg_p_q == seq_q.last_stage)
  ) else $error("stage order broken");
  a_full_no_gap: assert property (
    $fell(converting_q) |-> ctrl_q.power_mode != MODE_FULL
  ) else $error("full power sequence stopped");
  a_ctrl_readback: assert property (
    reg_read && reg_addr == OFFS_CTRL && !reg_write |=> reg_rdata_q == ctrl_q
  ) else $error("control readback differs");
  a_pair_exclusive: assert property (
    seq_q.diff_pair_en[0] |=> button_status_q[1:0]
      == ($past(button_raw[1:0]) == 2'h3 ? 2'h0 : $past(button_raw[1:0]))
  ) else $error("paired buttons reported wrongly");
  a_shutdown_stop: assert property (
    shut_req |=> ##[0:2] stopped ##1 stopped
  ) else $error("shutdown did not stop the sequencer");
  a_strobe_rate: assert property (
    sample_strobe_q |-> converting_q ##1 quiet_8
  ) else $error("sample strobe outside conversion or too dense");
endmodule

bind cdcseq_top cdcseq_top_asserts #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
  .conv_sample(conv_sample), .sample_strobe_q(sample_strobe_q),
  .button_raw(button_raw), .button_status_q(button_status_q),
  .active_stage_q(active_stage_q), .converting_q(converting_q),
  .positive_offset_setting_q(positive_offset_setting_q),
  .negative_offset_setting_q(negative_offset_setting_q)
);

// File: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cdcseq_pkg::*;
  localparam int MS_TICK = 10;
  localparam int T128    = 3 * 128 * SAMPLE_DIV;
  localparam int W200    = WAKE_STEP_MS * MS_TICK;
  logic                clk;
  logic                reset;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_write;
  logic                reg_read;
  logic [DATA_W-1:0]   reg_rdata_q;
  logic [DATA_W-1:0]   conv_sample;
  logic                sample_strobe_q;
  logic [7:0]          button_raw;
  logic [7:0]          button_status_q;
  logic [STAGE_W-1:0]  active_stage_q;
  logic [OFFSET_W-1:0] pos_q;
  logic [OFFSET_W-1:0] neg_q;
  logic                converting_q;
  logic [7:0]          raws [4] = '{8'h03, 8'h01, 8'h02, 8'h0F};
  logic [7:0]          outs [4] = '{8'h00, 8'h01, 8'h02, 8'h0C};
  int                  n_fail;
  int                  cmp_count;
  int                  n;

  cdcseq_top #(.MS_TICK_CYCLES(MS_TICK)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .conv_sample(conv_sample), .sample_strobe_q(sample_strobe_q),
    .button_raw(button_raw), .button_status_q(button_status_q),
    .active_stage_q(active_stage_q), .positive_offset_setting_q(pos_q),
    .negative_offset_setting_q(neg_q), .converting_q(converting_q)
  );
  cdcseq_conv_model u_conv (
    .sample_strobe_q(sample_strobe_q), .active_stage_q(active_stage_q),
    .conv_sample(conv_sample)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    chk(reg_rdata_q, exp);
  endtask

  // Waits on the stage (w=0) or on converting_q (w=1), never unbounded
  task automatic wait_for(input bit w, input logic [2:0] v, input int lim, output int cyc);
    cyc = 0;
    while ((w ? {2'h0, converting_q} : active_stage_q) !== v && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= lim) begin
      n_fail++;
      $display("[ERR] %0t wait limit reached", $time);
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset      = 1'b1;
    reg_addr   = '0;
    reg_wdata  = '0;
    reg_write  = 1'b0;
    reg_read   = 1'b0;
    button_raw = 8'h00;
    n_fail     = 0;
    cmp_count  = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd(OFFS_CTRL, CTRL_RESET);
    rd(OFFS_SEQ_CFG, SEQ_CFG_RESET);
    rd(10'h3FF, 16'h0000);
    chk({15'h0, converting_q}, 16'h0001);
    wr(OFFS_CTRL, 16'h0001);
    repeat (3) @(negedge clk);
    chk({12'h0, active_stage_q, converting_q}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(OFFS_CTRL, {12'h0, i[1:0], 2'h3});
      rd(OFFS_CTRL, {12'h0, i[1:0], 2'h3});
    end
    wr(OFFS_STAGE_CFG, 16'h0A05);
    wr(OFFS_STAGE_CFG + 10'h1, 16'h1122);
    wr(OFFS_SEQ_CFG, 16'h0FF7);
    rd(OFFS_SEQ_CFG, 16'h0FF7);
    wr(OFFS_SEQ_CFG, 16'h0031);
    wr(10'h3FF, 16'hFFFF);
    rd(OFFS_STAGE_CFG + 10'h1, 16'h1122);
    rd(10'h3FF, 16'h0000);
    wr(OFFS_CTRL, 16'h0100);
    repeat (3) @(negedge clk);
    chk({1'b0, neg_q, 1'b0, pos_q}, 16'h0A05);
    wait_for(0, 3'h1, 20000, n);
    chk({15'h0, (n >= T128 - 60 && n <= T128 + 60)}, 16'h0001);
    repeat (3) @(negedge clk);
    chk({1'b0, neg_q, 1'b0, pos_q}, 16'h1122);
    rd(OFFS_STATUS, 16'h0029);
    rd(OFFS_STAGE_RES, 16'h1000);
    rd(OFFS_RAW_RESULT, 16'h1000);
    wr(OFFS_SEQ_CFG, 16'h1031);
    for (int i = 0; i < 4; i++) begin
      button_raw = raws[i];
      repeat (2) @(negedge clk);
      chk({8'h0, button_status_q}, {8'h0, outs[i]});
    end
    button_raw = 8'h00;
    wait_for(0, 3'h0, 20000, n);
    chk({15'h0, converting_q}, 16'h0001);
    rd(OFFS_STAGE_RES + 10'h1, 16'h1111);
    rd(OFFS_RAW_RESULT, 16'h1111);
    wr(OFFS_CTRL, 16'h0001);
    wr(OFFS_SEQ_CFG, 16'h0010);
    wr(OFFS_CTRL, 16'h0102);
    wait_for(1, 3'h1, 20000, n);
    wait_for(1, 3'h0, 20000, n);
    wait_for(1, 3'h1, 20000, n);
    chk({15'h0, (n >= W200 - 20 && n <= W200 + 20)}, 16'h0001);
    button_raw = 8'h01;
    wait_for(1, 3'h0, 20000, n);
    wait_for(1, 3'h1, 100, n);
    chk({15'h0, (n < 20)}, 16'h0001);
    tally_and_finish();
  end
endmodule
